// ---- logic/wrt_core_if.sv ----
// Carrier between the register side and the counting core.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface wrt_core_if;
	import wrt_pkg::*;
	logic countEn;
	logic restart;
	logic [2:0] preSel;
	logic overflow;
	modport core (input countEn, input restart, input preSel, output overflow);
	modport ctrl (output countEn, output restart, output preSel, input overflow);
endinterface
`default_nettype wire

// ---- logic/wrt_pkg.sv ----
// Package for the watchdog reset timer: offsets, fields, resets, timing.
// Assumes one 25 MHz system clock and an 8-bit register port.
package wrt_pkg;

	// Register offsets
	localparam logic [7:0] WRT_WDOG_CTRL_ADDR = 8'hc1;
	localparam logic [7:0] WRT_FLASH_CTRL_ADDR = 8'hc7;

	// watchdog_control fields
	localparam int WRT_WC_FLAG = 7;
	localparam int WRT_WC_UNUSED = 6;
	localparam int WRT_WC_RUN = 5;
	localparam int WRT_WC_RESTART = 4;
	localparam int WRT_WC_IDLE = 3;
	localparam int WRT_WC_PS_HI = 2;
	localparam int WRT_WC_PS_LO = 0;

	// flash_prog_control fields
	localparam int WRT_FC_PROG_EN = 7;
	localparam int WRT_FC_BOOT_SEL = 6;
	localparam int WRT_FC_SOFT_RST = 5;
	localparam int WRT_FC_CMD_FAIL = 4;
	localparam int WRT_FC_WAIT_HI = 2;
	localparam int WRT_FC_WAIT_LO = 0;

	// Reset values
	localparam logic [2:0] WRT_PS_RESET = 3'h0;
	localparam logic [2:0] WRT_WAIT_RESET = 3'h0;
	localparam logic [15:0] WRT_BOOT_ADDR = 16'h0000;

	// Timing: system clocks per prescaler step, stage widths
	localparam int WRT_SYS_DIV = 12;
	localparam int WRT_DIV_W = 4;
	localparam logic [WRT_DIV_W-1:0] WRT_DIV_LAST = 4'(WRT_SYS_DIV - 1);
	localparam int WRT_PRE_W = 8;
	localparam int WRT_CNT_W = 15;

	typedef enum logic [1:0] {
		WRT_AREA_APP,
		WRT_AREA_MONITOR
	} wrt_area_t;

	typedef enum logic [2:0] {
		WRT_CAUSE_POWER,
		WRT_CAUSE_WDOG,
		WRT_CAUSE_PIN,
		WRT_CAUSE_SOFT
	} wrt_cause_t;

	// Prescaler terminal count: ratio 2**(sel+1), minus one
	function automatic logic [WRT_PRE_W-1:0] wrtPreLast(
		input logic [2:0] sel
	);
		logic [8:0] ratio;
		ratio = 9'h002 << sel;
		return WRT_PRE_W'(ratio - 9'h001);
	endfunction

endpackage

// ---- logic/wrt_watchdog_reset_timer.sv ----
// Watchdog reset timer top: control registers, reset sources, boot area.
// Assumes resetn is the power-on reset and all inputs share clk.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - 8-bit prescaler feeds 15-bit counter; counter overflow is the timeout.
// - Writing one to run enable starts counting.
// - Clearing run enable halts counting; no timeout while zero.
// - Counter overflow raises an internal system reset.
// - Overflow sets the top-bit reset flag; software clears it.
// - Restart bit zeroes prescaler and counter, then clears itself.
// - Idle bit one keeps counting in idle; zero suspends it.
// - Prescale select gives ratio two to the power select plus one.
// - Timeout is 12 times ratio times 32768 system clocks.
// - Watchdog, pin or 20h soft reset restart at application 0000h.
// - Writing 60h resets and restarts at boot monitor 0000h.
// - Cold boot starts in monitor; no download leads to application reset.
// - Watchdog reset keeps RAM; power-on leaves RAM undefined.
// - Flash control bit 5 resets and self-clears; bit 6 picks area.
// - Soft reset returns registers other than the reset flag, and ports, to initial values; no port logic here, and status outputs are not restored.
module wrt_watchdog_reset_timer
	import wrt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic cpuIdle,
	input wire logic resetPinReq,
	input wire logic monitorNoDownload,
	output logic sysResetReq,
	output logic bootFromMonitor,
	output logic [15:0] bootAddr,
	output logic coldBoot,
	output logic ramRetained,
	output logic [2:0] resetCause
);
	wrt_core_if cif ();

	// watchdog_control state
	logic flag_q;
	logic run_q;
	logic restart_q;
	logic idle_q;
	logic [2:0] ps_q;

	// flash_prog_control state
	logic progEn_q;
	logic bootSel_q;
	logic cmdFail_q;
	logic [2:0] wait_q;

	// Reset and boot state
	logic sysRst_q;
	wrt_area_t area_q;
	wrt_cause_t cause_q;
	logic cold_q;
	logic ramOk_q;
	logic [7:0] rdData_q;
	logic [7:0] wdogByte;
	logic [7:0] flashByte;
	logic flag_d;

	// Decoded accesses and events
	logic wrWdog;
	logic wrFlash;
	logic softRst;
	logic pinRst;
	logic wdogRst;
	logic monRst;
	logic anyRst;

	// Write aimed at one register; writes meeting a reset pulse are lost
	function automatic logic wrHit(
		input logic wr,
		input logic busy,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		return wr && !busy && (addr == target);
	endfunction

	assign wrWdog = wrHit(regWr, sysRst_q, regAddr, WRT_WDOG_CTRL_ADDR);
	assign wrFlash = wrHit(regWr, sysRst_q, regAddr, WRT_FLASH_CTRL_ADDR);
	assign wdogRst = cif.overflow;
	assign pinRst = resetPinReq;
	assign softRst = wrFlash && regWrData[WRT_FC_SOFT_RST];
	// Monitor found no download after cold boot
	assign monRst = monitorNoDownload && cold_q &&
		(area_q == WRT_AREA_MONITOR);
	assign anyRst = wdogRst || pinRst || softRst || monRst;

	// Core hookup
	assign cif.countEn = run_q && (!cpuIdle || idle_q);
	assign cif.restart = restart_q || sysRst_q;
	assign cif.preSel = ps_q;

	wrt_wdog_core u_core (
		.clk(clk),
		.resetn(resetn),
		.cif(cif)
	);

	// Internal system reset pulse, one cycle after the cause
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sysRst_q <= 1'b0;
		end else begin
			sysRst_q <= anyRst;
		end
	end

	// Next flag: a set outranks a software clear in the same cycle
	always_comb begin
		flag_d = flag_q;
		if (wrWdog && !regWrData[WRT_WC_FLAG]) begin
			flag_d = 1'b0;
		end
		if (wdogRst) begin
			flag_d = 1'b1;
		end
	end

	// Reset flag: only power-on clears it besides software
	always_ff @(posedge clk) begin
		if (!resetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// Run enable
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			run_q <= 1'b0;
		end else if (wrWdog) begin
			run_q <= regWrData[WRT_WC_RUN];
		end
	end

	// Counting in idle mode
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			idle_q <= 1'b0;
		end else if (wrWdog) begin
			idle_q <= regWrData[WRT_WC_IDLE];
		end
	end

	// Prescale select
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			ps_q <= WRT_PS_RESET;
		end else if (wrWdog) begin
			ps_q <= regWrData[WRT_WC_PS_HI:WRT_WC_PS_LO];
		end
	end

	// Restart bit lives one cycle, then hardware drops it
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			restart_q <= 1'b0;
		end else if (wrWdog && regWrData[WRT_WC_RESTART]) begin
			restart_q <= 1'b1;
		end else begin
			restart_q <= 1'b0;
		end
	end

	// Flash control storage; soft-reset bit is never stored
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			progEn_q <= 1'b0;
		end else if (wrFlash && !softRst) begin
			progEn_q <= regWrData[WRT_FC_PROG_EN];
		end
	end

	// Boot area select, plain storage until an internal system reset
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			bootSel_q <= 1'b0;
		end else if (wrFlash && !softRst) begin
			bootSel_q <= regWrData[WRT_FC_BOOT_SEL];
		end
	end

	// Command failure bit, plain storage
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			cmdFail_q <= 1'b0;
		end else if (wrFlash && !softRst) begin
			cmdFail_q <= regWrData[WRT_FC_CMD_FAIL];
		end
	end

	// Wait field, plain storage
	always_ff @(posedge clk) begin
		if (!resetn || sysRst_q) begin
			wait_q <= WRT_WAIT_RESET;
		end else if (wrFlash && !softRst) begin
			wait_q <= regWrData[WRT_FC_WAIT_HI:WRT_FC_WAIT_LO];
		end
	end

	// Boot area chosen by the reset source
	always_ff @(posedge clk) begin
		if (!resetn) begin
			area_q <= WRT_AREA_MONITOR;
		end else if (wdogRst || pinRst) begin
			area_q <= WRT_AREA_APP;
		end else if (softRst) begin
			area_q <= regWrData[WRT_FC_BOOT_SEL] ?
				WRT_AREA_MONITOR : WRT_AREA_APP;
		end else if (monRst) begin
			area_q <= WRT_AREA_APP;
		end
	end

	// Highest-ranked source of a warm reset
	function automatic wrt_cause_t causeOf(
		input logic wdog,
		input logic pin
	);
		if (wdog) begin
			return WRT_CAUSE_WDOG;
		end else if (pin) begin
			return WRT_CAUSE_PIN;
		end
		return WRT_CAUSE_SOFT;
	endfunction

	// Cause of the last reset; watchdog outranks pin, pin outranks soft
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cause_q <= WRT_CAUSE_POWER;
		end else if (anyRst) begin
			cause_q <= causeOf(wdogRst, pinRst);
		end
	end

	// Cold marker holds until the first warm reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cold_q <= 1'b1;
		end else if (anyRst) begin
			cold_q <= 1'b0;
		end
	end

	// RAM content only trusted after a warm reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ramOk_q <= 1'b0;
		end else if (anyRst) begin
			ramOk_q <= 1'b1;
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdData_q <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				WRT_WDOG_CTRL_ADDR: begin
					rdData_q <= wdogByte;
				end
				WRT_FLASH_CTRL_ADDR: begin
					rdData_q <= flashByte;
				end
				default: begin
					rdData_q <= 8'h00;
				end
			endcase
		end else begin
			rdData_q <= 8'h00;
		end
	end

	// Register images as software reads them
	assign wdogByte = {flag_q, 1'b0, run_q, restart_q, idle_q, ps_q};
	assign flashByte = {progEn_q, bootSel_q, 1'b0, cmdFail_q, 1'b0,
		wait_q};

	assign regRdData = rdData_q;
	assign sysResetReq = sysRst_q;
	assign bootFromMonitor = (area_q == WRT_AREA_MONITOR);
	assign bootAddr = WRT_BOOT_ADDR;
	assign coldBoot = cold_q;
	assign ramRetained = ramOk_q;
	assign resetCause = cause_q;
endmodule
`default_nettype wire

// ---- logic/wrt_wdog_core.sv ----
// Counting core: divide-by-twelve, 8-bit prescaler, 15-bit counter.
// Assumes restart is registered by the control side; countEn is combinational with cpuIdle.
`timescale 1ns/100ps
`default_nettype none
module wrt_wdog_core
	import wrt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	wrt_core_if.core cif
);
	logic [WRT_DIV_W-1:0] div_q;
	logic [WRT_PRE_W-1:0] pre_q;
	logic [WRT_CNT_W-1:0] cnt_q;
	logic ovf_q;
	logic divTick;
	logic preTick;

	assign divTick = cif.countEn && (div_q == WRT_DIV_LAST);
	assign preTick = divTick && (pre_q == wrtPreLast(cif.preSel));

	// Divide system clock by twelve
	always_ff @(posedge clk) begin
		if (!resetn || cif.restart) begin
			div_q <= '0;
		end else if (cif.countEn) begin
			div_q <= divTick ? '0 : div_q + 4'h1;
		end
	end

	// Prescaler stage
	always_ff @(posedge clk) begin
		if (!resetn || cif.restart) begin
			pre_q <= '0;
		end else if (divTick) begin
			pre_q <= preTick ? '0 : pre_q + 8'h01;
		end
	end

	// Main counter; wrap is the timeout
	always_ff @(posedge clk) begin
		if (!resetn || cif.restart) begin
			cnt_q <= '0;
		end else if (preTick) begin
			cnt_q <= cnt_q + 15'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn || cif.restart) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= preTick && (cnt_q == '1);
		end
	end

	assign cif.overflow = ovf_q;
endmodule
`default_nettype wire

// ---- verification/wrt_watchdog_reset_timer_asserts.sv ----
// Port checker for the watchdog reset timer.
// Assumes it is bound into wrt_watchdog_reset_timer.
`timescale 1ns/100ps
`default_nettype none
module wrt_watchdog_reset_timer_asserts
	import wrt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic resetPinReq,
	input wire logic monitorNoDownload,
	input wire logic sysResetReq,
	input wire logic bootFromMonitor,
	input wire logic coldBoot,
	input wire logic ramRetained,
	input wire logic [2:0] resetCause
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_restart;
		regWr && regAddr == WRT_WDOG_CTRL_ADDR && regWrData[4] && !sysResetReq;
	endsequence
	sequence s_rd_ctrl;
		regRd && regAddr == WRT_WDOG_CTRL_ADDR;
	endsequence
	property p_soft;
		regWr && regAddr == WRT_FLASH_CTRL_ADDR && regWrData[5] && !sysResetReq
			&& !resetPinReq |=> sysResetReq && resetCause == 3'h3
			&& bootFromMonitor == $past(regWrData[6]);
	endproperty
	property p_pulse;
		sysResetReq |=> !sysResetReq;
	endproperty
	property p_bit6;
		s_rd_ctrl |=> !regRdData[6];
	endproperty
	property p_restart;
		s_restart ##2 s_rd_ctrl |=> !regRdData[4];
	endproperty
	property p_warm;
		sysResetReq |-> !coldBoot && ramRetained;
	endproperty
	property p_pin;
		resetPinReq && !sysResetReq |=> sysResetReq && !bootFromMonitor
			&& resetCause == 3'h2;
	endproperty
	property p_clear;
		sysResetReq ##1 s_rd_ctrl |=> regRdData[5:0] == 6'h00;
	endproperty
	property p_fallback;
		monitorNoDownload && coldBoot && bootFromMonitor && !sysResetReq
			&& !resetPinReq && !regWr |=> sysResetReq && !bootFromMonitor
			&& resetCause == 3'h3;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset wrong");
	a_pulse: assert property (p_pulse) else $error("reset pulse long");
	a_bit6: assert property (p_bit6) else $error("bit 6 not zero");
	a_restart: assert property (p_restart) else $error("restart stuck");
	a_warm: assert property (p_warm) else $error("warm flags wrong");
	a_pin: assert property (p_pin) else $error("pin reset wrong");
	a_clear: assert property (p_clear) else $error("fields kept");
	a_fallback: assert property (p_fallback) else $error("no fallback");
endmodule
`default_nettype wire

// ---- verification/wrt_watchdog_reset_timer_bench.sv ----
// Bench for the watchdog reset timer: registers and reset sources.
// Assumes the checker is bound in below.
`timescale 1ns/100ps
`default_nettype none
module wrt_watchdog_reset_timer_bench
	import wrt_pkg::*;
;
	logic clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic cpuIdle = 1'b0, resetPinReq = 1'b0, monitorNoDownload = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d, a;
	logic sysResetReq, bootFromMonitor, coldBoot, ramRetained;
	logic [15:0] bootAddr;
	logic [2:0] resetCause;
	logic [7:0] sw [2] = '{8'h20, 8'h60};
	int fails = 0, nChecks = 0;
	integer seed = 32'h692f;
	always #20 clk = ~clk;
	wrt_watchdog_reset_timer i_wrt_watchdog_reset_timer(.clk, .resetn,
		.regAddr, .regWrData, .regWr, .regRd, .regRdData, .cpuIdle,
		.resetPinReq, .monitorNoDownload, .sysResetReq, .bootFromMonitor,
		.bootAddr, .coldBoot, .ramRetained, .resetCause);
	task automatic wrap_up;
		if (fails == 0 && nChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, exp, input string nm);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic st(input logic [7:0] exp);
		@(negedge clk);
		chk({bootAddr, sysResetReq, bootFromMonitor, coldBoot, ramRetained,
			1'b0, resetCause}, {16'h0000, exp}, "status");
	endtask
	task automatic wr(input logic [7:0] ad, dt);
		@(posedge clk);
		regAddr <= ad;
		regWrData <= dt;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, exp);
		@(posedge clk);
		regAddr <= ad;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk({16'h0000, regRdData}, {16'h0000, exp}, "read");
	endtask
	task automatic warm(input bit pinSel, input logic [7:0] exp);
		@(posedge clk);
		resetPinReq <= pinSel;
		monitorNoDownload <= !pinSel;
		@(posedge clk);
		resetPinReq <= 1'b0;
		monitorNoDownload <= 1'b0;
		st(exp);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		st(8'h60);
		warm(1'b0, 8'h93);
		rd(WRT_WDOG_CTRL_ADDR, 8'h00);
		rd(WRT_FLASH_CTRL_ADDR, 8'h00);
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			wr(WRT_WDOG_CTRL_ADDR, d);
			cpuIdle <= d[7];
			rd(WRT_WDOG_CTRL_ADDR, d & 8'h2f);
			d = 8'($random(seed)) & 8'hdf;
			wr(WRT_FLASH_CTRL_ADDR, d);
			rd(WRT_FLASH_CTRL_ADDR, d & 8'hd7);
			a = 8'($random(seed));
			if (a == WRT_WDOG_CTRL_ADDR || a == WRT_FLASH_CTRL_ADDR) a = 8'h00;
			rd(a, 8'h00);
		end
		foreach (sw[i]) begin
			wr(WRT_WDOG_CTRL_ADDR, 8'h2f);
			wr(WRT_FLASH_CTRL_ADDR, sw[i]);
			st({1'b1, sw[i][6], 6'h13});
			rd(WRT_WDOG_CTRL_ADDR, 8'h00);
			rd(WRT_FLASH_CTRL_ADDR, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			wr(WRT_WDOG_CTRL_ADDR, 8'h30);
			rd(WRT_WDOG_CTRL_ADDR, 8'h20);
			st(8'h53);
		end
		wr(WRT_WDOG_CTRL_ADDR, 8'h2b);
		warm(1'b1, 8'h92);
		rd(WRT_WDOG_CTRL_ADDR, 8'h00);
		@(posedge clk);
		resetn <= 1'b0;
		@(posedge clk);
		resetn <= 1'b1;
		st(8'h60);
		rd(WRT_WDOG_CTRL_ADDR, 8'h00);
		wrap_up;
	end
	initial begin
		#2000000;
		fails++;
		wrap_up;
	end
endmodule
bind wrt_watchdog_reset_timer wrt_watchdog_reset_timer_asserts i_chk(
	.clk, .resetn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
	.resetPinReq, .monitorNoDownload, .sysResetReq, .bootFromMonitor,
	.coldBoot, .ramRetained, .resetCause);
`default_nettype wire
